/* File: src/iah_pkg.sv */
package iah_pkg;
  // register offsets (byte addresses)
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_IRQ = 8'h04;
  localparam logic [7:0] OFF_IEN = 8'h08;
  localparam logic [7:0] OFF_PIN = 8'h0c;
  localparam logic [7:0] OFF_CMD = 8'h10;
  localparam logic [7:0] OFF_STAT = 8'h14;
  localparam logic [7:0] OFF_SAVE = 8'h18;
  // pin register field positions
  localparam int POS_ZC = 0;
  localparam int POS_EDGE_LO = 1;
  localparam int POS_EDGE_HI = 2;
  // command register fields
  localparam int POS_OPER = 0;
  localparam int POS_KIND = 4;
  // command kinds
  localparam logic [2:0] CMD_NONE = 3'h0;
  localparam logic [2:0] CMD_EI = 3'h1;
  localparam logic [2:0] CMD_TABLE_MOVE_INSTR = 3'h2;
  localparam logic [2:0] CMD_SKIP = 3'h3;
  localparam logic [2:0] CMD_HALT = 3'h4;
  localparam logic [2:0] CMD_STOP = 3'h5;
  localparam logic [2:0] CMD_PUSH = 3'h6;
  localparam logic [2:0] CMD_RETI = 3'h7;
  // standby operand bits
  localparam int OP_ANY = 3;
  localparam int OP_TM1 = 1;
  // timing
  localparam int STATE_CLKS = 4;
  localparam int STATES = 4;
  localparam int CYCLE_CLKS = STATE_CLKS * STATES;
  localparam int SAMPLE_STATE = 2;
  localparam int NEST_MAX = 3;
  localparam int TM1_SRC = 2;
  // reset values
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  typedef enum logic [1:0] {ST_RUN, ST_PREP, ST_HALT, ST_STOP} iah_st_type;
endpackage : iah_pkg

/* File: src/iah_top.sv */
// Behaviour
// - instruction cycle is 16 clocks, four states of four clocks.
// - pending requests are sampled at start of third state.
// - skipped instruction runs as no-op, then prep cycle, then vector.
// - prep cycle saves pc and status word, clears accepted flag.
// - table move takes two instruction cycles.
// - enable-interrupts blocks nesting during return from routine.
// - accepting an interrupt clears the master enable.
// - save stack holds three levels at most.
// - each interrupt uses one save level and one return level.
// - table move and push also use a return stack level.
// - zero-cross select bit routes pin via zero-cross path.
// - zero-cross pulse feeds timers and interrupt logic.
// - two edge-mode bits pick rising, falling or both edges.
// - stop halts oscillator; halt gates cpu clock only.
// - standby keeps state; stop with zero operand reinitialises.
// - no standby if b3 set and an enabled request pends, or halt b1 set and timer 1 flag set (enable not checked).
// - halt b3 releases on enabled request, b1 forced by timer 1.
// - halt with zero operand released only by reset.
// - halt with selected flag set acts as no-op.
// - after release resume next instruction or highest vector.
// - interrupt after move, enable or skip waits two cycles.
// - enable takes effect after the second following instruction completes.
// - pending requests served highest priority first.
// - request with source enable low stays pending.
`timescale 1ns/100ps
module iah_top #(
  parameter int NSRC = 5,
  parameter int PCW = 12,
  parameter int PSWW = 4
) (
  hclk,
  hresetn,
  hce,
  hsel,
  haddr,
  htrans,
  hwrite,
  hsize,
  hwdata,
  hready,
  hreadyout,
  hrdata,
  hresp,
  src_event,
  ext_pin,
  zc_in,
  pc_in,
  psw_in,
  cpu_clk_en,
  osc_en,
  soft_reinit,
  vector_valid,
  vector_idx,
  cycle_state,
  cnt_pulse
);
  input wire logic hclk;
  input wire logic hresetn;
  input wire logic hce;
  input wire logic hsel;
  input wire logic [31:0] haddr;
  input wire logic [1:0] htrans;
  input wire logic hwrite;
  input wire logic [2:0] hsize;
  input wire logic [31:0] hwdata;
  input wire logic hready;
  output logic hreadyout;
  output logic [31:0] hrdata;
  output logic hresp;
  input wire logic [NSRC-1:0] src_event;
  input wire logic ext_pin;
  input wire logic zc_in;
  input wire logic [PCW-1:0] pc_in;
  input wire logic [PSWW-1:0] psw_in;
  output logic cpu_clk_en;
  output logic osc_en;
  output logic soft_reinit;
  output logic vector_valid;
  output logic [2:0] vector_idx;
  output logic [1:0] cycle_state;
  output logic cnt_pulse;
  if (NSRC < 3 || NSRC > 8 || PCW + PSWW > 32) begin : g_param_chk
    $error("iah_top: unsupported parameters");
  end

  // ----------------------------------------
  // bus slave
  // ----------------------------------------
  logic wr_pend_r;
  logic [7:0] wr_addr_r;
  logic [31:0] rd_nxt;
  logic [31:0] wdat;
  logic wr_ctrl, wr_irq, wr_ien, wr_pin, wr_cmd;
  assign wdat = hwdata;
  assign wr_ctrl = wr_pend_r && wr_addr_r == iah_pkg::OFF_CTRL;
  assign wr_irq = wr_pend_r && wr_addr_r == iah_pkg::OFF_IRQ;
  assign wr_ien = wr_pend_r && wr_addr_r == iah_pkg::OFF_IEN;
  assign wr_pin = wr_pend_r && wr_addr_r == iah_pkg::OFF_PIN;
  assign wr_cmd = wr_pend_r && wr_addr_r == iah_pkg::OFF_CMD;
  logic [NSRC-1:0] irq_r, ien_r;
  logic master_irq_enable_r;
  logic [2:0] pin_cfg_r;
  logic [1:0] depth_r;
  logic [2:0] rdepth_r;
  logic [PCW+PSWW-1:0] save_r [iah_pkg::NEST_MAX];
  iah_pkg::iah_st_type st_r;
  always_comb begin
    rd_nxt = iah_pkg::RST_WORD;
    case (haddr[7:0])
      iah_pkg::OFF_CTRL: rd_nxt[0] = master_irq_enable_r;
      iah_pkg::OFF_IRQ: rd_nxt[NSRC-1:0] = irq_r;
      iah_pkg::OFF_IEN: rd_nxt[NSRC-1:0] = ien_r;
      iah_pkg::OFF_PIN: rd_nxt[2:0] = pin_cfg_r;
      iah_pkg::OFF_STAT: rd_nxt = {24'h000000, 1'b0, rdepth_r,
                                   depth_r, st_r};
      iah_pkg::OFF_SAVE:
        rd_nxt[PCW+PSWW-1:0] = (depth_r == 2'h0) ? '0 :
                               save_r[depth_r - 2'h1];
      default: rd_nxt = iah_pkg::RST_WORD;
    endcase
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else if (hce) begin
      wr_pend_r <= 1'b0;
      if (hsel && hready && htrans[1]) begin
        wr_pend_r <= hwrite;
        wr_addr_r <= haddr[7:0];
        if (!hwrite)
          hrdata <= rd_nxt;
      end
    end
  end

  // ----------------------------------------
  // instruction cycle timing
  // ----------------------------------------
  logic [3:0] clk_cnt_r;
  logic m2_lead, cyc_end;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      clk_cnt_r <= 4'h0;
    else if (hce)
      clk_cnt_r <= clk_cnt_r + 4'h1;
  end
  assign m2_lead = clk_cnt_r == 4'(iah_pkg::SAMPLE_STATE *
                                  iah_pkg::STATE_CLKS);
  assign cyc_end = clk_cnt_r == 4'(iah_pkg::CYCLE_CLKS - 1);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      cycle_state <= 2'h0;
    else if (hce)
      cycle_state <= clk_cnt_r[3:2];
  end

  // ----------------------------------------
  // pin path and edge detect
  // ----------------------------------------
  logic pin_sel, pin_d_r, rise, fall, pin_req;
  assign pin_sel = pin_cfg_r[iah_pkg::POS_ZC] ? zc_in : ext_pin;
  assign rise = pin_sel && !pin_d_r;
  assign fall = !pin_sel && pin_d_r;
  assign pin_req = (pin_cfg_r[iah_pkg::POS_EDGE_LO] && rise) ||
                   (pin_cfg_r[iah_pkg::POS_EDGE_HI] && fall);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_d_r <= 1'b0;
      pin_cfg_r <= 3'h0;
      cnt_pulse <= 1'b0;
    end else if (hce) begin
      pin_d_r <= pin_sel;
      cnt_pulse <= rise;
      if (wr_pin)
        pin_cfg_r <= wdat[2:0];
    end
  end

  // ----------------------------------------
  // control sequencer
  // ----------------------------------------
  logic [NSRC-1:0] pend, ev;
  logic [2:0] win;
  logic take_r, ei_pend_r, ei_arm_r;
  logic [1:0] hold_r;
  logic [2:0] kind_r;
  logic [3:0] oper_r;
  logic stop_zero;
  function automatic logic [2:0] prio(input logic [NSRC-1:0] v);
    prio = 3'h0;
    for (int i = NSRC - 1; i >= 0; i--)
      if (v[i])
        prio = 3'(i);
  endfunction : prio
  assign pend = irq_r & ien_r;
  assign win = prio(pend);
  assign ev = src_event | (NSRC'(pin_req));
  assign stop_zero = st_r == iah_pkg::ST_RUN && kind_r == iah_pkg::CMD_STOP
                     && oper_r == 4'h0 && cyc_end;
  genvar g;
  generate
    for (g = 0; g < NSRC; g++) begin : g_flag
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          irq_r[g] <= 1'b0;
          ien_r[g] <= 1'b0;
        end else if (hce) begin
          if (stop_zero) begin
            irq_r[g] <= 1'b0;
            ien_r[g] <= 1'b0;
          end else begin
            if (wr_ien)
              ien_r[g] <= wdat[g];
            if (ev[g])
              irq_r[g] <= 1'b1;
            else if (wr_irq)
              irq_r[g] <= wdat[g];
            else if (st_r == iah_pkg::ST_PREP && cyc_end && win == 3'(g))
              irq_r[g] <= 1'b0;
          end
        end
      end
    end
  endgenerate
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r <= iah_pkg::ST_RUN;
      master_irq_enable_r <= 1'b0;
      take_r <= 1'b0;
      ei_pend_r <= 1'b0;
      ei_arm_r <= 1'b0;
      hold_r <= 2'h0;
      kind_r <= iah_pkg::CMD_NONE;
      oper_r <= 4'h0;
      depth_r <= 2'h0;
      rdepth_r <= 3'h0;
      cpu_clk_en <= 1'b1;
      osc_en <= 1'b1;
      soft_reinit <= 1'b0;
      vector_valid <= 1'b0;
      vector_idx <= 3'h0;
    end else if (hce) begin
      vector_valid <= 1'b0;
      soft_reinit <= 1'b0;
      if (wr_ctrl)
        master_irq_enable_r <= wdat[0];
      if (m2_lead && st_r == iah_pkg::ST_RUN)
        take_r <= master_irq_enable_r && |pend && depth_r < 2'(iah_pkg::NEST_MAX);
      case (st_r)
        iah_pkg::ST_RUN: begin
          if (cyc_end) begin
            kind_r <= iah_pkg::CMD_NONE;
            ei_arm_r <= ei_pend_r;
            ei_pend_r <= 1'b0;
            if (ei_arm_r)
              master_irq_enable_r <= 1'b1;
            if (hold_r != 2'h0)
              hold_r <= hold_r - 2'h1;
            case (kind_r)
              iah_pkg::CMD_EI: begin
                ei_pend_r <= 1'b1;
                hold_r <= 2'h1;
              end
              iah_pkg::CMD_TABLE_MOVE_INSTR: begin
                hold_r <= 2'h1;
                rdepth_r <= rdepth_r + 3'h1;
              end
              iah_pkg::CMD_SKIP: begin
                hold_r <= 2'h1;
              end
              iah_pkg::CMD_PUSH:
                rdepth_r <= rdepth_r + 3'h1;
              iah_pkg::CMD_RETI: begin
                if (depth_r != 2'h0)
                  depth_r <= depth_r - 2'h1;
                if (rdepth_r != 3'h0)
                  rdepth_r <= rdepth_r - 3'h1;
              end
              iah_pkg::CMD_HALT: begin
                // selected flag set acts as no-op
                if (!((oper_r[iah_pkg::OP_ANY] && |pend) ||
                      (oper_r[iah_pkg::OP_TM1] &&
                       irq_r[iah_pkg::TM1_SRC]))) begin
                  st_r <= iah_pkg::ST_HALT;
                  cpu_clk_en <= 1'b0;
                end
              end
              iah_pkg::CMD_STOP: begin
                if (oper_r == 4'h0)
                  soft_reinit <= 1'b1;
                else if (!(oper_r[iah_pkg::OP_ANY] && |pend)) begin
                  st_r <= iah_pkg::ST_STOP;
                  cpu_clk_en <= 1'b0;
                  osc_en <= 1'b0;
                end
              end
              default: ;
            endcase
            if (take_r && hold_r == 2'h0 && kind_r != iah_pkg::CMD_TABLE_MOVE_INSTR &&
                kind_r != iah_pkg::CMD_EI && kind_r != iah_pkg::CMD_SKIP &&
                kind_r != iah_pkg::CMD_HALT && kind_r != iah_pkg::CMD_STOP)
              st_r <= iah_pkg::ST_PREP;
            take_r <= 1'b0;
          end
        end
        iah_pkg::ST_PREP: begin
          if (cyc_end) begin
            master_irq_enable_r <= 1'b0;
            depth_r <= depth_r + 2'h1;
            rdepth_r <= rdepth_r + 3'h1;
            vector_valid <= 1'b1;
            vector_idx <= win;
            st_r <= iah_pkg::ST_RUN;
          end
        end
        default: begin
          if ((oper_r[iah_pkg::OP_ANY] && |pend) ||
              (st_r == iah_pkg::ST_HALT && oper_r[iah_pkg::OP_TM1] &&
               irq_r[iah_pkg::TM1_SRC])) begin
            cpu_clk_en <= 1'b1;
            osc_en <= 1'b1;
            kind_r <= iah_pkg::CMD_NONE;
            st_r <= (master_irq_enable_r && |pend && depth_r < 2'(iah_pkg::NEST_MAX)) ?
                    iah_pkg::ST_PREP : iah_pkg::ST_RUN;
          end
        end
      endcase
      if (wr_cmd) begin
        kind_r <= wdat[iah_pkg::POS_KIND +: 3];
        oper_r <= wdat[iah_pkg::POS_OPER +: 4];
      end
    end
  end
  always_ff @(posedge hclk) begin
    if (hce && st_r == iah_pkg::ST_PREP && cyc_end &&
        depth_r < 2'(iah_pkg::NEST_MAX))
      save_r[depth_r] <= {pc_in, psw_in};
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_nest_limit: assert property (
    st_r == iah_pkg::ST_PREP |-> depth_r < 2'(iah_pkg::NEST_MAX))
    else $error("nesting above limit");
  a_accept_clears: assert property (
    vector_valid |-> !master_irq_enable_r)
    else $error("master enable still set");
  a_halt_gate: assert property (
    st_r == iah_pkg::ST_HALT |-> !cpu_clk_en && osc_en)
    else $error("halt clock gating wrong");
  a_stop_osc: assert property (
    st_r == iah_pkg::ST_STOP |-> !osc_en)
    else $error("stop left oscillator on");
  a_prep_len: assert property (
    hce && $rose(st_r == iah_pkg::ST_PREP) && clk_cnt_r == 4'h0
    |-> (st_r == iah_pkg::ST_PREP) [*8])
    else $error("prep cycle too short");
  a_vec_prio: assert property (
    hce && st_r == iah_pkg::ST_PREP && cyc_end
    |=> vector_valid && vector_idx == $past(win))
    else $error("wrong vector");
  a_depth_step: assert property (
    $rose(vector_valid) |-> depth_r == $past(depth_r) + 2'h1)
    else $error("save level not consumed");
  a_ei_delay: assert property (
    hce && cyc_end && kind_r == iah_pkg::CMD_EI && !master_irq_enable_r
    && !ei_arm_r && !wr_ctrl |=> !master_irq_enable_r)
    else $error("enable took effect early");
endmodule : iah_top

/* File: verif/iah_top_tb.sv */
`timescale 1ns/100ps
module iah_top_tb;
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hce = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0000_0000;
  logic hreadyout;
  logic [31:0] hrdata;
  logic hresp;
  logic [4:0] src_event = 5'h00;
  logic ext_pin = 1'b0;
  logic zc_in = 1'b0;
  logic [11:0] pc_in = 12'h5a3;
  logic [3:0] psw_in = 4'h9;
  logic cpu_clk_en;
  logic osc_en;
  logic soft_reinit;
  logic vector_valid;
  logic [2:0] vector_idx;
  logic [1:0] cycle_state;
  logic cnt_pulse;
  logic [31:0] rd;
  int errors = 0;
  int n_checks = 0;
  int n_cnt = 0;
  int n_reinit = 0;
  int k0;

  always #2 hclk = ~hclk;

  always @(posedge hclk) begin
    if (cnt_pulse === 1'b1) n_cnt++;
    if (soft_reinit === 1'b1) n_reinit++;
  end

  iah_top iah_top_i (
    .hclk(hclk), .hresetn(hresetn), .hce(hce), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .src_event(src_event),
    .ext_pin(ext_pin), .zc_in(zc_in), .pc_in(pc_in), .psw_in(psw_in),
    .cpu_clk_en(cpu_clk_en), .osc_en(osc_en), .soft_reinit(soft_reinit),
    .vector_valid(vector_valid), .vector_idx(vector_idx),
    .cycle_state(cycle_state), .cnt_pulse(cnt_pulse)
  );

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic give_verdict;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic bus(input logic wr_en, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= wr_en;
    hsize <= 3'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task automatic rdm(input string what, input logic [7:0] a,
                     input logic [31:0] m, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    chk(what, exp, rd & m);
  endtask : rdm

  function automatic logic [31:0] cmd(input logic [2:0] k,
                                      input logic [3:0] op);
    return {25'h0000000, k, op};
  endfunction : cmd

  task automatic do_reset;
    @(posedge hclk);
    hresetn <= 1'b0;
    src_event <= 5'h00;
    ext_pin <= 1'b0;
    zc_in <= 1'b0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
  endtask : do_reset

  task automatic ev(input int s);
    @(posedge hclk);
    src_event[s] <= 1'b1;
    @(posedge hclk);
    src_event <= 5'h00;
  endtask : ev

  task automatic idle(input int n);
    repeat (n) @(posedge hclk);
  endtask : idle

  task automatic pins(input logic p, input logic z);
    @(posedge hclk);
    ext_pin <= p;
    zc_in <= z;
    idle(8);
  endtask : pins

  task automatic wait_vec(input logic expv, input logic [2:0] eidx,
                          input string what);
    logic seen;
    logic [2:0] idx;
    seen = 1'b0;
    idx = 3'h0;
    for (int i = 0; i < 80 && !seen; i++) begin
      @(posedge hclk);
      if (vector_valid === 1'b1) begin
        seen = 1'b1;
        idx = vector_idx;
      end
    end
    chk(what, {31'h0, expv}, {31'h0, seen});
    if (expv) chk(what, {29'h0, eidx}, {29'h0, idx});
  endtask : wait_vec

  // ------------------------------------------------------------
  // watchdog
  // ------------------------------------------------------------
  initial begin
    idle(20000);
    errors++;
    give_verdict;
  end

  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    do_reset;
    chk("hresp", 32'h0, {31'h0, hresp});
    for (int a = 0; a <= 28; a += 4) begin
      rdm("reset word", a[7:0], 32'hffff_ffff, 32'h0);
    end
    while (cycle_state !== 2'h3) @(posedge hclk);
    while (cycle_state !== 2'h0) @(posedge hclk);
    for (int k = 1; k <= 16; k++) begin
      @(posedge hclk);
      if (k % 4 == 0)
        chk("state", (k / 4) % 4, {30'h0, cycle_state});
    end
    hce <= 1'b0;
    idle(2);
    rd = {30'h0, cycle_state};
    idle(8);
    chk("freeze", rd, {30'h0, cycle_state});
    hce <= 1'b1;
    wr(iah_pkg::OFF_IEN, 32'h0000_001a);
    wr(iah_pkg::OFF_CTRL, 32'h0000_0001);
    ev(1);
    wait_vec(1'b1, 3'h1, "accept");
    rdm("master", iah_pkg::OFF_CTRL, 32'h1, 32'h0);
    rdm("flag", iah_pkg::OFF_IRQ, 32'h2, 32'h0);
    rdm("save", iah_pkg::OFF_SAVE, 32'hffff, 32'h5a39);
    rdm("depth", iah_pkg::OFF_STAT, 32'h7c, 32'h14);
    wr(iah_pkg::OFF_IRQ, 32'h0000_0001);
    wr(iah_pkg::OFF_CTRL, 32'h0000_0001);
    wait_vec(1'b0, 3'h0, "held");
    wr(iah_pkg::OFF_IRQ, 32'h0000_0019);
    wait_vec(1'b1, 3'h3, "prio a");
    wr(iah_pkg::OFF_CTRL, 32'h0000_0001);
    wait_vec(1'b1, 3'h4, "prio b");
    wr(iah_pkg::OFF_IRQ, 32'h0000_0003);
    wr(iah_pkg::OFF_CTRL, 32'h0000_0001);
    wait_vec(1'b0, 3'h0, "nest");
    rdm("depth", iah_pkg::OFF_STAT, 32'h7c, 32'h3c);
    rdm("pending", iah_pkg::OFF_IRQ, 32'h1, 32'h1);
    wr(iah_pkg::OFF_CTRL, 32'h0000_0000);
    wr(iah_pkg::OFF_CMD, cmd(iah_pkg::CMD_RETI, 4'h0));
    idle(32);
    rdm("reti", iah_pkg::OFF_STAT, 32'h7c, 32'h28);
    wr(iah_pkg::OFF_CTRL, 32'h0000_0001);
    wait_vec(1'b1, 3'h1, "refill");
    do_reset;
    wr(iah_pkg::OFF_CMD, cmd(iah_pkg::CMD_PUSH, 4'h0));
    idle(32);
    rdm("push", iah_pkg::OFF_STAT, 32'h7c, 32'h10);
    wr(iah_pkg::OFF_CMD, cmd(iah_pkg::CMD_TABLE_MOVE_INSTR, 4'h0));
    idle(48);
    rdm("move", iah_pkg::OFF_STAT, 32'h7c, 32'h20);
    wr(iah_pkg::OFF_CMD, cmd(iah_pkg::CMD_EI, 4'h0));
    rdm("ei early", iah_pkg::OFF_CTRL, 32'h1, 32'h0);
    idle(48);
    rdm("ei late", iah_pkg::OFF_CTRL, 32'h1, 32'h1);
    do_reset;
    wr(iah_pkg::OFF_IEN, 32'h0000_0002);
    ev(1);
    wr(iah_pkg::OFF_CMD, cmd(iah_pkg::CMD_SKIP, 4'h0));
    wr(iah_pkg::OFF_CTRL, 32'h0000_0001);
    k0 = 3;
    while (vector_valid !== 1'b1 && k0 < 100) begin
      @(posedge hclk);
      k0++;
    end
    chk("skip delay", 32'h1, {31'h0, k0 >= 50 && k0 <= 65});
    chk("skip vector", 32'h1, {29'h0, vector_idx});
    do_reset;
    wr(iah_pkg::OFF_PIN, 32'h0000_0002);
    k0 = n_cnt;
    pins(1'b1, 1'b0);
    rdm("rise", iah_pkg::OFF_IRQ, 32'h1, 32'h1);
    chk("count", k0 + 1, n_cnt);
    wr(iah_pkg::OFF_IRQ, 32'h0000_0000);
    pins(1'b0, 1'b0);
    rdm("fall off", iah_pkg::OFF_IRQ, 32'h1, 32'h0);
    wr(iah_pkg::OFF_PIN, 32'h0000_0004);
    pins(1'b1, 1'b0);
    rdm("rise off", iah_pkg::OFF_IRQ, 32'h1, 32'h0);
    pins(1'b0, 1'b0);
    rdm("fall", iah_pkg::OFF_IRQ, 32'h1, 32'h1);
    wr(iah_pkg::OFF_IRQ, 32'h0000_0000);
    wr(iah_pkg::OFF_PIN, 32'h0000_0007);
    k0 = n_cnt;
    pins(1'b1, 1'b0);
    rdm("zc pin", iah_pkg::OFF_IRQ, 32'h1, 32'h0);
    pins(1'b1, 1'b1);
    rdm("zc", iah_pkg::OFF_IRQ, 32'h1, 32'h1);
    chk("zc count", k0 + 1, n_cnt);
    do_reset;
    wr(iah_pkg::OFF_IEN, 32'h0000_0002);
    idle(16);
    wr(iah_pkg::OFF_CMD, cmd(iah_pkg::CMD_HALT, 4'h0));
    idle(40);
    chk("halt cpu", 32'h0, {31'h0, cpu_clk_en});
    chk("halt osc", 32'h1, {31'h0, osc_en});
    ev(1);
    idle(40);
    rdm("halt zero", iah_pkg::OFF_STAT, 32'h3, 32'h2);
    do_reset;
    wr(iah_pkg::OFF_IEN, 32'h0000_0002);
    wr(iah_pkg::OFF_CMD, cmd(iah_pkg::CMD_HALT, 4'h2));
    idle(40);
    ev(1);
    idle(40);
    chk("b1 only", 32'h0, {31'h0, cpu_clk_en});
    ev(2);
    idle(40);
    chk("forced", 32'h1, {31'h0, cpu_clk_en});
    rdm("kept", iah_pkg::OFF_IEN, 32'h1f, 32'h2);
    wr(iah_pkg::OFF_CMD, cmd(iah_pkg::CMD_HALT, 4'h8));
    idle(40);
    chk("halt nop", 32'h1, {31'h0, cpu_clk_en});
    rdm("no standby", iah_pkg::OFF_STAT, 32'h3, 32'h0);
    wr(iah_pkg::OFF_CMD, cmd(iah_pkg::CMD_STOP, 4'h0));
    idle(40);
    chk("reinit", 32'h1, n_reinit);
    do_reset;
    wr(iah_pkg::OFF_IEN, 32'h0000_0008);
    wr(iah_pkg::OFF_CTRL, 32'h0000_0001);
    wr(iah_pkg::OFF_CMD, cmd(iah_pkg::CMD_STOP, 4'h8));
    idle(40);
    chk("stop osc", 32'h0, {31'h0, osc_en});
    ev(3);
    wait_vec(1'b1, 3'h3, "stop wake");
    chk("osc back", 32'h1, {31'h0, osc_en});
    give_verdict;
  end
endmodule : iah_top_tb
